/* rtl/flow_unit.sv */
// flow unit: jumps, calls, skips, branches and i/o bit ops behind an ahb-lite slave
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module flow_unit import flow_pkg::*; #(
	parameter int STACK_DEPTH = 16
) (
	input  wire logic        clk_sys_in,
	input  wire logic        nrst_in,
	input  wire logic        clk_en_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic      [15:0] pc_out,
	output logic             busy_out
);
	localparam int SAW = $clog2(STACK_DEPTH);

	state_type   state_r;
	logic [31:0] instr_r;
	logic [15:0] pc_r, ptr_r;
	logic [7:0]  status_register_r;
	logic [7:0]  wreg_mem [32];
	logic [7:0]  io_mem [32];
	logic [15:0] stack_mem [STACK_DEPTH];
	logic [SAW-1:0] sp_r;
	logic [1:0]  wait_cnt_r, last_cyc_r;
	logic        last_skip_r, last_taken_r, last_bad_r;
	logic        dp_valid_r, dp_write_r, dp_hi_r, rd_done_r;
	logic [11:0] dp_addr_r;
	logic [31:0] hrdata_r, rd_mux;
	logic        stall, wr_fire, launch, run;
	logic        in_wreg, in_io;
	logic [4:0]  reg_idx;

	// instruction fields and operands
	op_type      op;
	logic [4:0]  rd_idx, rr_idx;
	logic [2:0]  bsel;
	logic [7:0]  imm, rd_val, rr_val, io_val;
	logic        two_word, io_hi;
	logic [15:0] br_target, k_ext;

	// execution results
	logic [15:0] pc_nxt;
	logic [7:0]  status_register_nxt;
	logic [1:0]  cyc_nxt;
	logic        skip, br_take, bad, push, io_we, io_bit_val;
	logic        cz, cn, cv, cc, ch;

	assign op        = op_type'(instr_r[OP_LSB +: 5]);
	assign rd_idx    = instr_r[RD_LSB +: 5];
	assign rr_idx    = instr_r[RR_LSB +: 5];
	assign bsel      = instr_r[BIT_LSB +: 3];
	assign imm       = instr_r[IMM_LSB +: 8];
	assign two_word  = instr_r[TWO_WORD_BIT];
	assign io_hi     = instr_r[IO_HI_BIT];
	assign rd_val    = wreg_mem[rd_idx];
	assign rr_val    = wreg_mem[rr_idx];
	assign io_val    = io_mem[rr_idx];
	assign k_ext     = {{9{imm[6]}}, imm[6:0]};
	assign br_target = pc_r + k_ext + 16'h0001;
	assign run       = (state_r == ST_RUN);

	sub_flags #(.W(8), .HALF_BIT(3)) u_cmp (
		.a_in      (rd_val),
		.b_in      (imm),
		.zero_out  (cz),
		.neg_out   (cn),
		.ovf_out   (cv),
		.carry_out (cc),
		.half_out  (ch)
	);

	// bus handshake: the master waits while an instruction runs or the clock is gated
	assign stall         = (state_r != ST_IDLE) | ~clk_en_in;
	assign hreadyout_out = clk_en_in & (~dp_valid_r | (dp_write_r ? ~stall : rd_done_r));
	assign hresp_out     = 1'b0;
	assign hrdata_out    = hrdata_r;
	assign wr_fire       = dp_valid_r & dp_write_r & ~stall & ~dp_hi_r;
	assign in_wreg       = (dp_addr_r[11:7] == WREG_REGION);
	assign in_io         = (dp_addr_r[11:7] == IO_REGION);
	assign reg_idx       = dp_addr_r[6:2];
	assign launch        = wr_fire & ~in_wreg & ~in_io & (dp_addr_r == OFS_INSTR);
	assign pc_out        = pc_r;
	assign busy_out      = (state_r != ST_IDLE);

	// address phase capture; upper address bits make the access unmapped
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_hi_r    <= 1'b0;
			dp_addr_r  <= 12'h000;
		end else if (clk_en_in && hready_in) begin
			dp_valid_r <= hsel_in & htrans_in[1];
			dp_write_r <= hwrite_in;
			dp_hi_r    <= |haddr_in[31:12];
			dp_addr_r  <= {haddr_in[11:2], 2'b00};
		end
	end

	// read data is registered one cycle into the data phase, after any instruction ends
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (dp_hi_r) begin
			rd_mux = 32'h0000_0000;
		end else if (in_wreg) begin
			rd_mux = {24'h000000, wreg_mem[reg_idx]};
		end else if (in_io) begin
			rd_mux = {24'h000000, io_mem[reg_idx]};
		end else begin
			case (dp_addr_r)
				OFS_INSTR:     rd_mux = instr_r;
				OFS_PC:        rd_mux = {16'h0000, pc_r};
				OFS_POINTER:   rd_mux = {16'h0000, ptr_r};
				OFS_STATUS:    rd_mux = {24'h000000, status_register_r};
				OFS_STATE: begin
					rd_mux[ST_BUSY_BIT]         = busy_out;
					rd_mux[ST_SKIP_BIT]         = last_skip_r;
					rd_mux[ST_TAKEN_BIT]        = last_taken_r;
					rd_mux[ST_ILLEGAL_BIT]      = last_bad_r;
					rd_mux[ST_CYC_LSB +: 2]     = last_cyc_r;
					rd_mux[ST_SP_LSB +: SAW]    = sp_r;
				end
				OFS_STACK_TOP: rd_mux = {16'h0000, stack_mem[sp_r - SAW'(1)]};
				default:       rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			hrdata_r  <= 32'h0000_0000;
			rd_done_r <= 1'b0;
		end else if (clk_en_in) begin
			if (hready_in) begin
				rd_done_r <= 1'b0;
			end else if (dp_valid_r && !dp_write_r && !stall) begin
				hrdata_r  <= rd_mux;
				rd_done_r <= 1'b1;
			end
		end
	end

	// decode and execute, evaluated during the single run cycle
	always_comb begin
		pc_nxt     = pc_r + 16'h0001;
		status_register_nxt   = status_register_r;
		cyc_nxt    = CYC_PLAIN;
		skip       = 1'b0;
		br_take    = 1'b0;
		bad        = 1'b0;
		push       = 1'b0;
		io_we      = 1'b0;
		io_bit_val = 1'b0;
		case (op)
			OP_POINTER_JUMP: begin
				pc_nxt  = ptr_r;
				cyc_nxt = CYC_POINTER_JUMP;
			end
			OP_POINTER_CALL: begin
				pc_nxt  = ptr_r;
				push    = 1'b1;
				cyc_nxt = CYC_POINTER_CALL;
			end
			OP_COMPARE_SKIP_EQUAL:   skip = (rd_val == rr_val);
			OP_COMPARE_IMMEDIATE: begin
				status_register_nxt[FLAG_Z] = cz;
				status_register_nxt[FLAG_N] = cn;
				status_register_nxt[FLAG_V] = cv;
				status_register_nxt[FLAG_C] = cc;
				status_register_nxt[FLAG_H] = ch;
			end
			OP_SKIP_REG_BIT_CLEAR:   skip = ~rr_val[bsel];
			OP_SKIP_REG_BIT_SET:     skip = rr_val[bsel];
			OP_SKIP_IO_BIT_CLEAR:    {bad, skip} = {io_hi, ~io_hi & ~io_val[bsel]};
			OP_SKIP_IO_BIT_SET:      {bad, skip} = {io_hi, ~io_hi & io_val[bsel]};
			OP_BRANCH_FLAG_SET:      br_take = status_register_r[bsel];
			OP_BRANCH_FLAG_CLEAR:    br_take = ~status_register_r[bsel];
			OP_BRANCH_UNSIGNED_GE:   br_take = ~status_register_r[FLAG_C];
			OP_BRANCH_UNSIGNED_LT:   br_take = status_register_r[FLAG_C];
			OP_BRANCH_CARRY_CLEAR:   br_take = ~status_register_r[FLAG_C];
			OP_BRANCH_CARRY_SET:     br_take = status_register_r[FLAG_C];
			OP_BRANCH_SIGNED_GE:     br_take = ~(status_register_r[FLAG_N] ^ status_register_r[FLAG_V]);
			OP_BRANCH_SIGNED_LT:     br_take = status_register_r[FLAG_N] ^ status_register_r[FLAG_V];
			OP_BRANCH_HALFCARRY_SET: br_take = status_register_r[FLAG_H];
			OP_BRANCH_HALFCARRY_CLR: br_take = ~status_register_r[FLAG_H];
			OP_BRANCH_XFER_BIT_SET:  br_take = status_register_r[FLAG_T];
			OP_BRANCH_XFER_BIT_CLR:  br_take = ~status_register_r[FLAG_T];
			OP_BRANCH_OVERFLOW_SET:  br_take = status_register_r[FLAG_V];
			OP_BRANCH_OVERFLOW_CLR:  br_take = ~status_register_r[FLAG_V];
			OP_BRANCH_IRQ_ENABLED:   br_take = status_register_r[FLAG_I];
			OP_BRANCH_IRQ_DISABLED:  br_take = ~status_register_r[FLAG_I];
			OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
				// the upper half of i/o space has no bit access: treated as illegal
				if (io_hi) begin
					bad = 1'b1;
				end else begin
					io_we      = 1'b1;
					io_bit_val = (op == OP_IO_BIT_SET);
					cyc_nxt    = CYC_IO_BIT;
				end
			end
			default: bad = 1'b1;
		endcase
		if (skip) begin
			pc_nxt  = pc_r + (two_word ? 16'h0003 : 16'h0002);
			cyc_nxt = two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;
		end
		if (br_take) begin
			pc_nxt  = br_target;
			cyc_nxt = CYC_BRANCH_TAKEN;
		end
	end

	// sequencer: one run cycle, then wait cycles to make up the instruction length
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			state_r    <= ST_IDLE;
			wait_cnt_r <= 2'h0;
		end else if (clk_en_in) begin
			case (state_r)
				ST_IDLE: if (launch) state_r <= ST_RUN;
				ST_RUN: begin
					wait_cnt_r <= cyc_nxt - 2'h1;
					state_r    <= (cyc_nxt == CYC_PLAIN) ? ST_IDLE : ST_WAIT;
				end
				ST_WAIT: begin
					wait_cnt_r <= wait_cnt_r - 2'h1;
					if (wait_cnt_r == 2'h1) state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// instruction word and outcome record
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			instr_r      <= INSTR_RST;
			last_cyc_r   <= 2'h0;
			last_skip_r  <= 1'b0;
			last_taken_r <= 1'b0;
			last_bad_r   <= 1'b0;
		end else if (clk_en_in) begin
			if (launch) instr_r <= hwdata_in;
			if (run) begin
				last_cyc_r   <= cyc_nxt;
				last_skip_r  <= skip;
				last_taken_r <= br_take;
				last_bad_r   <= bad;
			end
		end
	end

	// program counter, pointer and status: bus writes only land while idle
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			pc_r   <= PC_RST;
			ptr_r  <= POINTER_RST;
			status_register_r <= STATUS_RST;
		end else if (clk_en_in) begin
			if (run) begin
				pc_r   <= pc_nxt;
				status_register_r <= status_register_nxt;
			end else if (wr_fire && !in_wreg && !in_io) begin
				if (dp_addr_r == OFS_PC) pc_r <= hwdata_in[15:0];
				if (dp_addr_r == OFS_POINTER) ptr_r <= hwdata_in[15:0];
				if (dp_addr_r == OFS_STATUS) status_register_r <= hwdata_in[7:0];
			end
		end
	end

	// return stack: next address stored on the same edge as the pc moves
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			sp_r <= '0;
		end else if (clk_en_in && run && push) begin
			stack_mem[sp_r] <= pc_r + 16'h0001;
			sp_r            <= sp_r + SAW'(1);
		end
	end

	// working registers and low i/o space; bit ops write one bit so w1c neighbours survive
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 32; i++) begin
				wreg_mem[i] <= 8'h00;
				io_mem[i]   <= 8'h00;
			end
		end else if (clk_en_in) begin
			if (run && io_we) begin
				io_mem[rr_idx][bsel] <= io_bit_val;
			end else if (wr_fire && in_wreg) begin
				wreg_mem[reg_idx] <= hwdata_in[7:0];
			end else if (wr_fire && in_io) begin
				io_mem[reg_idx] <= hwdata_in[7:0];
			end
		end
	end

	a_jump_target: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && op == OP_POINTER_JUMP |=> pc_r == $past(ptr_r) && state_r == ST_WAIT)
		else $error("pointer jump did not load pointer in two cycles");
	a_call_length: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && op == OP_POINTER_CALL |=> state_r == ST_WAIT [*2] ##1 state_r == ST_IDLE)
		else $error("pointer call did not take three cycles");
	a_call_push: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && op == OP_POINTER_CALL |=>
		stack_mem[$past(sp_r)] == $past(pc_r) + 16'h0001 && sp_r == $past(sp_r) + SAW'(1))
		else $error("call did not push the return address");
	a_equal_skip: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && op == OP_COMPARE_SKIP_EQUAL && rd_val == rr_val && !two_word |=>
		pc_r == $past(pc_r) + 16'h0002)
		else $error("equal compare did not skip one word");
	a_compare_flags: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && op == OP_COMPARE_IMMEDIATE |=> state_r == ST_IDLE &&
		status_register_r[FLAG_Z] == ($past(rd_val) == $past(imm)) &&
		status_register_r[FLAG_C] == ($past(rd_val) < $past(imm)) && status_register_r[7:6] == $past(status_register_r[7:6]))
		else $error("compare immediate flags or length wrong");
	a_flags_kept: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && op != OP_COMPARE_IMMEDIATE |=> $stable(status_register_r))
		else $error("flow instruction changed the status flags");
	a_branch_target: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && br_take |=> pc_r == $past(br_target) ##1 state_r == ST_IDLE)
		else $error("taken branch target or length wrong");
	a_branch_fall: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && op >= OP_BRANCH_FLAG_SET && op <= OP_BRANCH_IRQ_DISABLED && !br_take
		|=> state_r == ST_IDLE && pc_r == $past(pc_r) + 16'h0001)
		else $error("untaken branch not one cycle");
	a_signed_ge: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && op == OP_BRANCH_SIGNED_GE |-> br_take == (status_register_r[FLAG_N] == status_register_r[FLAG_V]))
		else $error("signed ge condition wrong");
	a_skip_two_word: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && skip && two_word |=> state_r == ST_WAIT [*2] ##1 state_r == ST_IDLE)
		else $error("two-word skip not three cycles");
	a_io_bit_only: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && io_we |=> io_mem[$past(rr_idx)] ==
		(($past(io_val) & ~(8'h01 << $past(bsel))) | ({7'h00, $past(io_bit_val)} << $past(bsel))))
		else $error("i/o bit op touched other bits");
	a_io_high_refused: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		run && clk_en_in && io_hi && (op == OP_IO_BIT_SET || op == OP_SKIP_IO_BIT_SET) |=>
		last_bad_r && io_mem[$past(rr_idx)] == $past(io_val))
		else $error("bit access above 0x1f not refused");

endmodule : flow_unit

/* rtl/flow_pkg.sv */
// package: offsets, field layout, reset values, cycle counts and codes of the flow unit
package flow_pkg;

	// register byte offsets on the bus
	localparam logic [11:0] OFS_INSTR     = 12'h000;
	localparam logic [11:0] OFS_PC        = 12'h004;
	localparam logic [11:0] OFS_POINTER   = 12'h008;
	localparam logic [11:0] OFS_STATUS    = 12'h00c;
	localparam logic [11:0] OFS_STATE     = 12'h010;
	localparam logic [11:0] OFS_STACK_TOP = 12'h014;
	localparam logic [4:0]  WREG_REGION   = 5'h02;   // 0x100..0x17c, haddr[11:7]
	localparam logic [4:0]  IO_REGION     = 5'h03;   // 0x180..0x1fc, haddr[11:7]

	// instruction word fields
	localparam int OP_LSB       = 0;
	localparam int RD_LSB       = 5;
	localparam int RR_LSB       = 10;
	localparam int BIT_LSB      = 15;
	localparam int IMM_LSB      = 18;
	localparam int TWO_WORD_BIT = 26;
	localparam int IO_HI_BIT    = 27;

	// state word fields
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_SKIP_BIT    = 1;
	localparam int ST_TAKEN_BIT   = 2;
	localparam int ST_ILLEGAL_BIT = 3;
	localparam int ST_CYC_LSB     = 4;
	localparam int ST_SP_LSB      = 8;

	// status register flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// values after reset
	localparam logic [15:0] PC_RST      = 16'h0000;
	localparam logic [15:0] POINTER_RST = 16'h0000;
	localparam logic [7:0]  STATUS_RST  = 8'h00;
	localparam logic [31:0] INSTR_RST   = 32'h0000_0000;

	// cycle counts
	localparam logic [1:0] CYC_PLAIN        = 2'h1;
	localparam logic [1:0] CYC_POINTER_JUMP = 2'h2;
	localparam logic [1:0] CYC_POINTER_CALL = 2'h3;
	localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
	localparam logic [1:0] CYC_IO_BIT       = 2'h2;
	localparam logic [1:0] CYC_SKIP_ONE     = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO     = 2'h3;

	typedef enum logic [4:0] {
		OP_POINTER_JUMP         = 5'h00,
		OP_POINTER_CALL         = 5'h01,
		OP_COMPARE_SKIP_EQUAL   = 5'h02,
		OP_COMPARE_IMMEDIATE    = 5'h03,
		OP_SKIP_REG_BIT_CLEAR   = 5'h04,
		OP_SKIP_REG_BIT_SET     = 5'h05,
		OP_SKIP_IO_BIT_CLEAR    = 5'h06,
		OP_SKIP_IO_BIT_SET      = 5'h07,
		OP_BRANCH_FLAG_SET      = 5'h08,
		OP_BRANCH_FLAG_CLEAR    = 5'h09,
		OP_BRANCH_UNSIGNED_GE   = 5'h0a,
		OP_BRANCH_UNSIGNED_LT   = 5'h0b,
		OP_BRANCH_CARRY_CLEAR   = 5'h0c,
		OP_BRANCH_CARRY_SET     = 5'h0d,
		OP_BRANCH_SIGNED_GE     = 5'h0e,
		OP_BRANCH_SIGNED_LT     = 5'h0f,
		OP_BRANCH_HALFCARRY_SET = 5'h10,
		OP_BRANCH_HALFCARRY_CLR = 5'h11,
		OP_BRANCH_XFER_BIT_SET  = 5'h12,
		OP_BRANCH_XFER_BIT_CLR  = 5'h13,
		OP_BRANCH_OVERFLOW_SET  = 5'h14,
		OP_BRANCH_OVERFLOW_CLR  = 5'h15,
		OP_BRANCH_IRQ_ENABLED   = 5'h16,
		OP_BRANCH_IRQ_DISABLED  = 5'h17,
		OP_IO_BIT_SET           = 5'h18,
		OP_IO_BIT_CLEAR         = 5'h19
	} op_type;

	// gray codes along idle, run, wait
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_WAIT = 2'b11
	} state_type;

endpackage : flow_pkg

/* rtl/sub_flags.sv */
// subtract-and-compare flag unit: result is not kept, only the flags
`timescale 1ns/1ps
module sub_flags #(
	parameter int W        = 8,
	parameter int HALF_BIT = 3
) (
	input  wire logic [W-1:0] a_in,
	input  wire logic [W-1:0] b_in,
	output logic              zero_out,
	output logic              neg_out,
	output logic              ovf_out,
	output logic              carry_out,
	output logic              half_out
);
	logic [W-1:0] diff;

	// overflow and half borrow from operand and result bits; carry from an unsigned compare
	always_comb begin
		diff      = a_in - b_in;
		zero_out  = (diff == '0);
		neg_out   = diff[W-1];
		ovf_out   = (a_in[W-1] & ~b_in[W-1] & ~diff[W-1]) | (~a_in[W-1] & b_in[W-1] & diff[W-1]);
		carry_out = (a_in < b_in);
		half_out  = (~a_in[HALF_BIT] & b_in[HALF_BIT]) | (b_in[HALF_BIT] & diff[HALF_BIT])
			| (diff[HALF_BIT] & ~a_in[HALF_BIT]);
	end
endmodule : sub_flags

/* dv/branch_skip_bit_flow_unit_tb.sv */
// self-checking bench for the flow unit: bus tasks, instruction table, edge cases
`timescale 1ns/1ps
module branch_skip_bit_flow_unit_tb import flow_pkg::*;;
	typedef struct packed {
		logic [4:0]  op;
		logic [7:0]  st;
		logic [4:0]  rr;
		logic [2:0]  b;
		logic [7:0]  imm;
		logic        two;
		logic [15:0] epc;
		logic [1:0]  cyc;
	} row_type;

	logic        clk_sys_in;
	logic        nrst_in;
	logic        clk_en_in;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] pc;
	logic        busy;
	logic [31:0] d;
	int          n;
	int          err_total = 0;
	int          checked = 0;
	int          cycles = 0;
	row_type     rows [29];

	flow_unit #(.STACK_DEPTH(16)) u_dut (
		.clk_sys_in    (clk_sys_in),
		.nrst_in       (nrst_in),
		.clk_en_in     (clk_en_in),
		.hsel_in       (1'b1),
		.haddr_in      (haddr),
		.htrans_in     (htrans),
		.hwrite_in     (hwrite),
		.hsize_in      (3'h2),
		.hwdata_in     (hwdata),
		.hready_in     (hreadyout),
		.hrdata_out    (hrdata),
		.hreadyout_out (hreadyout),
		.hresp_out     (hresp),
		.pc_out        (pc),
		.busy_out      (busy)
	);

	// 25 mhz
	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// a hang is cut short well past the expected run length
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// ready and read data are taken at the rising edge; both come from flops, so no race
	task automatic wait_rdy(output logic [31:0] rd);
		logic r;
		r = 1'b0;
		while (r !== 1'b1) begin
			@(posedge clk_sys_in);
			r  = hreadyout;
			rd = hrdata;
		end
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		wait_rdy(rd);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(rd);
	endtask : bus

	task automatic bw(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] j;
		bus(1'b1, a, wd, j);
	endtask : bw

	task automatic br(input logic [31:0] a, output logic [31:0] rd);
		bus(1'b0, a, 32'h0, rd);
	endtask : br

	function automatic logic [31:0] enc(input logic [4:0] op, input logic [4:0] rdf,
		input logic [4:0] rr, input logic [2:0] b, input logic [7:0] imm, input logic two);
		return {5'h0, two, imm, b, rr, rdf, op};
	endfunction : enc

	// launch one instruction and count the cycles busy stays high
	task automatic run(input logic [31:0] ins, output int cnt);
		logic [31:0] j;
		bus(1'b1, 32'h0, ins, j);
		cnt = 0;
		@(negedge clk_sys_in);
		while (busy === 1'b1 && cnt < 8) begin
			cnt++;
			@(negedge clk_sys_in);
		end
		@(posedge clk_sys_in);
	endtask : run

	// compare immediate: flags from a-k, register left as it was
	task automatic cmpi(input logic [7:0] a, input logic [7:0] k, input logic [7:0] st,
		input logic [7:0] e);
		bw(32'h104, 32'(a));
		bw(32'(OFS_STATUS), 32'(st));
		run(enc(5'h03, 5'h1, 5'h0, 3'h0, k, 1'b0), n);
		chk("cmp cycles", 32'(n), 32'h1);
		br(32'(OFS_STATUS), d);
		chk("cmp flags", d, 32'(e));
		br(32'h104, d);
		chk("cmp reg", d, 32'(a));
	endtask : cmpi

	initial begin
		nrst_in = 1'b0;
		clk_en_in = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		// op, flags, rr, bit, imm, two-word, pc after, cycles; base pc 0x100
		rows = '{'{5'h00,8'h00,5'h0,3'h0,8'h00,1'b0,16'h1234,2'h2},
			'{5'h01,8'h00,5'h0,3'h0,8'h00,1'b0,16'h1234,2'h3},
			'{5'h02,8'h00,5'h2,3'h0,8'h00,1'b0,16'h0102,2'h2},
			'{5'h02,8'h00,5'h2,3'h0,8'h00,1'b1,16'h0103,2'h3},
			'{5'h02,8'h00,5'h3,3'h0,8'h00,1'b0,16'h0101,2'h1},
			'{5'h04,8'h00,5'h2,3'h1,8'h00,1'b0,16'h0102,2'h2},
			'{5'h04,8'h00,5'h2,3'h0,8'h00,1'b0,16'h0101,2'h1},
			'{5'h05,8'h00,5'h2,3'h0,8'h00,1'b1,16'h0103,2'h3},
			'{5'h06,8'h00,5'h2,3'h1,8'h00,1'b0,16'h0102,2'h2},
			'{5'h07,8'h00,5'h2,3'h1,8'h00,1'b0,16'h0101,2'h1},
			'{5'h08,8'h80,5'h0,3'h7,8'h05,1'b0,16'h0106,2'h2},
			'{5'h09,8'h80,5'h0,3'h7,8'h05,1'b0,16'h0101,2'h1},
			'{5'h09,8'h80,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h0a,8'h00,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h0b,8'h00,5'h0,3'h0,8'h05,1'b0,16'h0101,2'h1},
			'{5'h0c,8'h01,5'h0,3'h0,8'h05,1'b0,16'h0101,2'h1},
			'{5'h0d,8'h01,5'h0,3'h0,8'h7d,1'b0,16'h00fe,2'h2},
			'{5'h0e,8'h0c,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h0f,8'h04,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h10,8'h20,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h11,8'h20,5'h0,3'h0,8'h05,1'b0,16'h0101,2'h1},
			'{5'h12,8'h40,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h13,8'h00,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h14,8'h00,5'h0,3'h0,8'h05,1'b0,16'h0101,2'h1},
			'{5'h15,8'h08,5'h0,3'h0,8'h05,1'b0,16'h0101,2'h1},
			'{5'h16,8'h80,5'h0,3'h0,8'h05,1'b0,16'h0106,2'h2},
			'{5'h17,8'h80,5'h0,3'h0,8'h05,1'b0,16'h0101,2'h1},
			'{5'h18,8'h00,5'h3,3'h0,8'h00,1'b0,16'h0101,2'h2},
			'{5'h19,8'h00,5'h3,3'h1,8'h00,1'b0,16'h0101,2'h2}};
		repeat (6) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		chk("busy rst", 32'(busy), 32'h0);
		chk("ready rst", 32'(hreadyout), 32'h1);
		br(32'(OFS_PC), d);
		chk("pc rst", d, 32'(PC_RST));
		br(32'(OFS_POINTER), d);
		chk("pointer rst", d, 32'(POINTER_RST));
		br(32'(OFS_STATUS), d);
		chk("status rst", d, 32'(STATUS_RST));
		// operands shared by the table: reg1 = reg2 = io2 = a5, reg3 = 5a
		bw(32'(OFS_POINTER), 32'h1234);
		bw(32'h104, 32'ha5);
		bw(32'h108, 32'ha5);
		bw(32'h10c, 32'h5a);
		bw(32'h188, 32'ha5);
		foreach (rows[i]) begin
			bw(32'(OFS_PC), 32'h100);
			bw(32'(OFS_STATUS), 32'(rows[i].st));
			run(enc(rows[i].op, 5'h1, rows[i].rr, rows[i].b, rows[i].imm, rows[i].two), n);
			chk("cycles", 32'(n), 32'(rows[i].cyc));
			chk("pc", 32'(pc), 32'(rows[i].epc));
			br(32'(OFS_STATUS), d);
			chk("flags kept", d, 32'(rows[i].st));
			br(32'(OFS_STATE), d);
			chk("state cyc", 32'(d[ST_CYC_LSB +: 2]), 32'(rows[i].cyc));
		end
		// zero, borrow with negative, overflow with half borrow; S T I kept
		cmpi(8'ha5, 8'ha5, 8'hd0, 8'hd2);
		cmpi(8'h10, 8'h20, 8'hd0, 8'hd5);
		cmpi(8'h80, 8'h01, 8'h00, 8'h28);
		// single bit ops leave the neighbours alone
		bw(32'h190, 32'hf0);
		run(enc(5'h18, 5'h0, 5'h4, 3'h0, 8'h00, 1'b0), n);
		br(32'h190, d);
		chk("bit set", d, 32'hf1);
		run(enc(5'h19, 5'h0, 5'h4, 3'h7, 8'h00, 1'b0), n);
		br(32'h190, d);
		chk("bit clear", d, 32'h71);
		// address 0x24 is out of reach of the bit ops
		run(enc(5'h18, 5'h0, 5'h4, 3'h3, 8'h00, 1'b0) | 32'h0800_0000, n);
		br(32'h190, d);
		chk("high io", d, 32'h71);
		br(32'(OFS_STATE), d);
		chk("illegal", 32'(d[ST_ILLEGAL_BIT]), 32'h1);
		// return address lands on the stack
		bw(32'(OFS_PC), 32'h200);
		run(enc(5'h01, 5'h0, 5'h0, 3'h0, 8'h00, 1'b0), n);
		br(32'(OFS_STACK_TOP), d);
		chk("return addr", d, 32'h201);
		chk("call pc", 32'(pc), 32'h1234);
		bw(32'h2000, 32'hffff_ffff);
		br(32'h2000, d);
		chk("unmapped", d, 32'h0);
		chk("resp", 32'(hresp), 32'h0);
		// reset again while a call sits in its wait cycles
		bw(32'(OFS_INSTR), enc(5'h01, 5'h0, 5'h0, 3'h0, 8'h00, 1'b0));
		@(posedge clk_sys_in);
		chk("busy mid", 32'(busy), 32'h1);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(negedge clk_sys_in);
		chk("pc rst2", 32'(pc), 32'(PC_RST));
		chk("busy rst2", 32'(busy), 32'h0);
		@(posedge clk_sys_in);
		br(32'(OFS_STATE), d);
		chk("state rst2", d, 32'h0);
		br(32'(OFS_POINTER), d);
		chk("pointer rst2", d, 32'(POINTER_RST));
		stop_test();
	end
endmodule : branch_skip_bit_flow_unit_tb
